// File: rtl/sfps_flash_seq.sv
// Purpose: Program/erase/reset command sequencer of a serial NOR flash
// Assumes: i_sclk runs only inside frames; cs high for >= 6 sys clocks
// Notes:   Array itself is outside; it follows o_op_* and the page buffer
//
// Overview of operation
// - Extended quad program: opcode, 3/4 address bytes, data, quad lines.
// - Over 256 data bytes: later bytes overwrite earlier ones in page.
// - Under 256 bytes: only written bytes are marked, rest untouched.
// - Frame ending off a byte boundary abandons the program.
// - Accepted command starts timed cycle; busy flag high until done.
// - Write enable latch cleared before each cycle completes.
// - Program into a protected page is not executed.
// - Sector erase 20H/21H, any address inside sector, latch set.
// - Sector erase runs for its own sector erase time.
// - Erase frame must end right after last address byte.
// - Sector erase into a protected sector is not executed.
// - 32KB block erase 52H/5CH runs small block erase time.
// - 64KB block erase D8H/DCH runs large block erase time.
// - Block erase into a protected block is refused.
// - Chip erase 60H/C7H alone, ends after opcode, runs array time.
// - Chip erase ignored while any sector is protected.
// - 24-bit addresses by default, 32-bit in four-byte mode.
// - Software reset aborts operation and clears volatile state.
// - Reset needs 66H frame then 99H frame; anything else cancels.
// - Commands rejected during reset recovery time.
// - Opcode 06H alone sets the write enable latch.
`default_nettype none

module sfps_flash_seq
    import sfps_pkg::*;
#(
    parameter int unsigned ADDR_W = 24,
    parameter int unsigned PROG_US = sfps_pkg::PROG_TIME_US,
    parameter int unsigned SEC_US = sfps_pkg::SEC_TIME_US,
    parameter int unsigned B32_US = sfps_pkg::B32_TIME_US,
    parameter int unsigned B64_US = sfps_pkg::B64_TIME_US,
    parameter int unsigned CHIP_US = sfps_pkg::CHIP_TIME_US,
    parameter int unsigned RREC_US = sfps_pkg::RST_REC_US
) (
    input wire logic i_sys_clk,            // System clock
    input wire logic i_srst,               // Synchronous reset
    input wire logic i_sclk,               // Serial clock from host
    input wire logic i_cs_n,               // Chip select, low in frame
    input wire logic [3:0] i_io,           // Serial data lines IO3..IO0
    input wire logic i_four_byte_mode,     // 32-bit addressing
    input wire logic i_top_bottom,         // Protect from bottom when 1
    input wire logic [3:0] i_protect_level, // Protect level bits
    input wire logic [7:0] i_pbuf_idx,     // Page buffer read index
    output logic [7:0] o_pbuf_data,        // Page buffer byte
    output logic o_pbuf_valid,             // Byte was written
    output logic o_write_enable_latch,     // Write enable latch
    output logic o_op_in_progress_flag,    // Timed cycle running
    output logic o_reset_busy,             // Reset recovery running
    output logic o_op_start,               // Array operation start pulse
    output sfps_pkg::sfps_op_t o_op_kind,  // Operation kind
    output logic [31:0] o_op_addr,         // Operation address
    output logic o_op_done,                // Operation finished pulse
    output logic o_op_abort,               // Operation aborted pulse
    output logic o_soft_reset              // Volatile state clear pulse
);
    import sfps_pkg::*;

    localparam int unsigned PROG_CYC = PROG_US * CLK_MHZ;
    localparam int unsigned SEC_CYC = SEC_US * CLK_MHZ;
    localparam int unsigned B32_CYC = B32_US * CLK_MHZ;
    localparam int unsigned B64_CYC = B64_US * CLK_MHZ;
    localparam int unsigned CHIP_CYC = CHIP_US * CLK_MHZ;
    localparam int unsigned RREC_CYC = RREC_US * CLK_MHZ;
    localparam int unsigned BLK_W = ADDR_W - BLOCK_LSB;

    function automatic logic is_epp(input logic [7:0] opc);
        return opc == OPC_EPP_A || opc == OPC_EPP_B;
    endfunction

    // Protection check on the 64KB block holding the address
    function automatic logic is_prot(input logic [31:0] addr,
                                     input logic tb,
                                     input logic [3:0] lvl);
        logic [31:0] blk;
        logic [31:0] nprot;
        logic [31:0] total;
        blk = addr >> BLOCK_LSB;
        total = 32'h1 << BLK_W;
        nprot = (lvl == 4'h0) ? 32'h0 : (32'h1 << (lvl - 4'h1));
        if (nprot > total)
            nprot = total;
        if (blk >= total)
            return 1'b1;
        return tb ? (blk < nprot) : (blk >= total - nprot);
    endfunction

    function automatic logic [31:0] op_cycles(input sfps_op_t k);
        case (k)
            OP_PROG: return 32'(PROG_CYC);
            OP_SEC: return 32'(SEC_CYC);
            OP_BLK32: return 32'(B32_CYC);
            OP_BLK64: return 32'(B64_CYC);
            OP_CHIP: return 32'(CHIP_CYC);
            default: return 32'h1;
        endcase
    endfunction

    // ---------------- Link domain, clocked by i_sclk ----------------
    logic live_r;
    logic tog_r;
    logic four_lk;
    logic [7:0] opc_r;
    logic [7:0] sh_r;
    logic [2:0] bpos_r;
    logic [2:0] nbyte_r;
    logic [31:0] laddr_r;
    logic [7:0] col_r;
    logic [7:0] pbuf_r [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pmask_r;
    logic quad_w;
    logic [2:0] nb_w;
    logic [2:0] bp_nxt;
    logic [7:0] sh_nxt;
    logic [2:0] alen_lk;
    logic done_w;

    sfps_sync #(.W(1)) u_sync_four (
        .i_clk(i_sclk),
        .i_d(i_four_byte_mode),
        .o_q(four_lk)
    );

    // Frame's own select ends the live state; no edge needed after it
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n)
            live_r <= 1'b0;
        else
            live_r <= 1'b1;
    end

    // One toggle per frame that saw clock edges
    always_ff @(posedge i_sclk or posedge i_srst) begin
        if (i_srst)
            tog_r <= 1'b0;
        else if (!live_r)
            tog_r <= ~tog_r;
    end

    always_comb begin
        nb_w = live_r ? nbyte_r : 3'h0;
        alen_lk = four_lk ? ALEN_4B : ALEN_3B;
        quad_w = (nb_w != 3'h0) && is_epp(opc_r);
        sh_nxt = quad_w ? {sh_r[3:0], i_io} : {sh_r[6:0], i_io[0]};
        bp_nxt = (live_r ? bpos_r : 3'h0) + (quad_w ? 3'h4 : 3'h1);
        done_w = (bp_nxt == 3'h0);
    end

    always_ff @(posedge i_sclk) begin
        sh_r <= sh_nxt;
        bpos_r <= bp_nxt;
        if (done_w && nb_w != NBYTE_MAX)
            nbyte_r <= nb_w + 3'h1;
        else
            nbyte_r <= nb_w;
    end

    always_ff @(posedge i_sclk) begin
        if (done_w) begin
            if (nb_w == 3'h0)
                opc_r <= sh_nxt;
            else if (nb_w == 3'h1)
                laddr_r <= {24'h0, sh_nxt};
            else if (nb_w <= alen_lk)
                laddr_r <= {laddr_r[23:0], sh_nxt};
        end
    end

    always_ff @(posedge i_sclk) begin
        if (done_w && nb_w == alen_lk)
            col_r <= sh_nxt;
        else if (done_w && nb_w > alen_lk && is_epp(opc_r))
            col_r <= col_r + 8'h1;
    end

    always_ff @(posedge i_sclk) begin
        if (!live_r) begin
            pmask_r <= '0;
        end else if (done_w && nb_w > alen_lk && is_epp(opc_r)) begin
            pbuf_r[col_r] <= sh_nxt;
            pmask_r[col_r] <= 1'b1;
        end
    end

    // ---------------- System domain ----------------
    // Link state is static once select is high, so it is read directly
    logic cs_s;
    logic tog_s;
    logic cs_d_r;
    logic seen_r;
    logic frame_w;
    logic [2:0] alen_w;
    logic aligned_w;
    logic solo_w;
    logic addr_ok_w;
    logic epp_ok_w;
    logic [31:0] addr_w;
    logic prot_w;
    sfps_op_t kind_w;
    logic go_w;
    logic set_write_latch_cmd_w;
    logic rst_en_w;
    logic rst_w;
    sfps_state_t state_r;
    sfps_state_t state_nxt;
    logic [31:0] cnt_r;
    logic wel_r;
    logic rsten_r;

    sfps_sync #(.W(2)) u_sync_link (
        .i_clk(i_sys_clk),
        .i_d({i_cs_n, tog_r}),
        .o_q({cs_s, tog_s})
    );

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cs_d_r <= 1'b1;
            seen_r <= 1'b0;
        end else begin
            cs_d_r <= cs_s;
            if (cs_s && !cs_d_r)
                seen_r <= tog_s;
        end
    end

    always_comb begin
        frame_w = cs_s && !cs_d_r && (tog_s != seen_r);
        alen_w = i_four_byte_mode ? ALEN_4B : ALEN_3B;
        aligned_w = (bpos_r == 3'h0);
        solo_w = aligned_w && nbyte_r == 3'h1;
        addr_ok_w = aligned_w && nbyte_r == alen_w + 3'h1;
        epp_ok_w = aligned_w && nbyte_r >= alen_w + 3'h2;
        // upper byte dropped in 3-byte mode
        addr_w = i_four_byte_mode ? laddr_r : {8'h0, laddr_r[23:0]};
        kind_w = OP_NONE;
        case (opc_r)
            OPC_EPP_A, OPC_EPP_B:
                if (epp_ok_w)
                    kind_w = OP_PROG;
            OPC_SE_A, OPC_SE_B:
                if (addr_ok_w)
                    kind_w = OP_SEC;
            OPC_B32_A, OPC_B32_B:
                if (addr_ok_w)
                    kind_w = OP_BLK32;
            OPC_B64_A, OPC_B64_B:
                if (addr_ok_w)
                    kind_w = OP_BLK64;
            OPC_CE_A, OPC_CE_B:
                if (solo_w)
                    kind_w = OP_CHIP;
            default:
                kind_w = OP_NONE;
        endcase
        if (kind_w == OP_CHIP)
            prot_w = (i_protect_level != 4'h0);
        else
            prot_w = is_prot(addr_w, i_top_bottom, i_protect_level);
        go_w = frame_w && state_r == ST_IDLE && kind_w != OP_NONE
            && wel_r && !prot_w;
        set_write_latch_cmd_w = frame_w && state_r == ST_IDLE && solo_w
            && opc_r == OPC_SET_WRITE_LATCH_CMD;
        rst_en_w = frame_w && state_r != ST_RECOV && solo_w
            && opc_r == OPC_RST_EN;
        rst_w = frame_w && state_r != ST_RECOV && solo_w
            && opc_r == OPC_RST && rsten_r;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst)
            rsten_r <= 1'b0;
        else if (frame_w)
            rsten_r <= rst_en_w;
    end

    // latch cleared on start and reset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || go_w || rst_w)
            wel_r <= 1'b0;
        else if (set_write_latch_cmd_w)
            wel_r <= 1'b1;
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (rst_w)
                    state_nxt = ST_RECOV;
                else if (go_w)
                    state_nxt = ST_BUSY;
            ST_BUSY:
                if (rst_w)
                    state_nxt = ST_RECOV;
                else if (cnt_r == 32'h1)
                    state_nxt = ST_IDLE;
            ST_RECOV:
                if (cnt_r == 32'h1)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst)
            cnt_r <= 32'h0;
        else if (rst_w)
            cnt_r <= 32'(RREC_CYC);
        else if (go_w)
            cnt_r <= op_cycles(kind_w);
        else if (cnt_r != 32'h0)
            cnt_r <= cnt_r - 32'h1;
    end

    // start on select rise, flag while running
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_op_start <= 1'b0;
            o_op_kind <= OP_NONE;
            o_op_addr <= 32'h0;
            o_op_done <= 1'b0;
            o_op_in_progress_flag <= 1'b0;
        end else begin
            o_op_start <= go_w;
            if (go_w) begin
                o_op_kind <= kind_w;
                o_op_addr <= addr_w;
            end
            o_op_done <= state_r == ST_BUSY && !rst_w && cnt_r == 32'h1;
            o_op_in_progress_flag <= state_nxt == ST_BUSY;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_op_abort <= 1'b0;
            o_soft_reset <= 1'b0;
            o_reset_busy <= 1'b0;
        end else begin
            o_op_abort <= rst_w && state_r == ST_BUSY;
            o_soft_reset <= rst_w;
            o_reset_busy <= state_nxt == ST_RECOV;
        end
    end

    // Buffer is only stable while select is high between frames
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_pbuf_data <= 8'h00;
            o_pbuf_valid <= 1'b0;
        end else begin
            o_pbuf_data <= pbuf_r[i_pbuf_idx];
            o_pbuf_valid <= pmask_r[i_pbuf_idx];
        end
    end

    assign o_write_enable_latch = wel_r;
endmodule

`default_nettype wire

// File: rtl/sfps_pkg.sv
// Purpose: Shared constants for the serial flash program/erase sequencer
// Assumes: System clock at 40 MHz
// Notes:   Operation times are plain defaults; the top overrides all but RST_REC_US
`default_nettype none

package sfps_pkg;
    // Opcodes, two accepted codes per program/erase command, one for the others
    localparam logic [7:0] OPC_EPP_A = 8'hC2;
    localparam logic [7:0] OPC_EPP_B = 8'h3E;
    localparam logic [7:0] OPC_SE_A = 8'h20;
    localparam logic [7:0] OPC_SE_B = 8'h21;
    localparam logic [7:0] OPC_B32_A = 8'h52;
    localparam logic [7:0] OPC_B32_B = 8'h5C;
    localparam logic [7:0] OPC_B64_A = 8'hD8;
    localparam logic [7:0] OPC_B64_B = 8'hDC;
    localparam logic [7:0] OPC_CE_A = 8'h60;
    localparam logic [7:0] OPC_CE_B = 8'hC7;
    localparam logic [7:0] OPC_SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] OPC_RST_EN = 8'h66;
    localparam logic [7:0] OPC_RST = 8'h99;

    // Address lengths, byte count cap and page size in bytes; block address LSB
    localparam logic [2:0] ALEN_3B = 3'h3;
    localparam logic [2:0] ALEN_4B = 3'h4;
    localparam logic [2:0] NBYTE_MAX = 3'h7;
    localparam int unsigned PAGE_BYTES = 256;
    localparam int unsigned BLOCK_LSB = 16;

    // Clock rate and default operation times in microseconds
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned PROG_TIME_US = 1000;
    localparam int unsigned SEC_TIME_US = 2000;
    localparam int unsigned B32_TIME_US = 4000;
    localparam int unsigned B64_TIME_US = 8000;
    localparam int unsigned CHIP_TIME_US = 100000;
    localparam int unsigned RST_REC_US = 40;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_PROG = 3'h1,
        OP_SEC = 3'h2,
        OP_BLK32 = 3'h3,
        OP_BLK64 = 3'h4,
        OP_CHIP = 3'h5
    } sfps_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_RECOV = 3'b100
    } sfps_state_t;
endpackage

`default_nettype wire

// File: rtl/sfps_sync.sv
// Purpose: Two-stage level synchroniser
// Assumes: Input is a level that holds for several destination clocks
// Notes:   No reset; output settles two edges after the input
`default_nettype none

module sfps_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,       // Destination clock
    input wire logic [W-1:0] i_d, // Asynchronous level
    output logic [W-1:0] o_q      // Synchronised level
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk) begin
        meta_r <= i_d;
        o_q <= meta_r;
    end
endmodule

`default_nettype wire

// File: sim/serial_flash_program_erase_reset_tb_top.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Short operation times through parameters
// Notes:   Host model drives the link, bench watches ports
`default_nettype none

module serial_flash_program_erase_reset_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sfps_pkg::*;
    logic i_sys_clk, i_srst, sclk, cs_n, four_b, tob;
    logic pvalid, write_enable_latch, busy, rbusy, start, done, abort, srst_p;
    logic st_seen, rs_seen, ab_seen;
    logic [3:0] io, lvl;
    logic [7:0] idx, pdata;
    logic [31:0] oaddr, st_addr;
    sfps_op_t kind, st_kind;
    logic [7:0] exp_d [0:255];
    logic exp_v [0:255];
    int err_count, comparisons;
    integer seed;
    logic [7:0] ops [8] = '{OPC_SE_A, OPC_SE_B, OPC_B32_A, OPC_B32_B,
        OPC_B64_A, OPC_B64_B, OPC_CE_A, OPC_CE_B};
    sfps_op_t kinds [8] = '{OP_SEC, OP_SEC, OP_BLK32, OP_BLK32,
        OP_BLK64, OP_BLK64, OP_CHIP, OP_CHIP};

    sfps_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(io));

    sfps_flash_seq #(.PROG_US(1), .SEC_US(1), .B32_US(1), .B64_US(2),
        .CHIP_US(3)) dut_u (
        .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_io(io), .i_four_byte_mode(four_b),
        .i_top_bottom(tob), .i_protect_level(lvl), .i_pbuf_idx(idx),
        .o_pbuf_data(pdata), .o_pbuf_valid(pvalid),
        .o_write_enable_latch(write_enable_latch), .o_op_in_progress_flag(busy),
        .o_reset_busy(rbusy), .o_op_start(start), .o_op_kind(kind),
        .o_op_addr(oaddr), .o_op_done(done), .o_op_abort(abort),
        .o_soft_reset(srst_p));

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        if (start === 1'b1) begin
            st_seen <= 1'b1;
            st_kind <= kind;
            st_addr <= oaddr;
        end
        if (srst_p === 1'b1) rs_seen <= 1'b1;
        if (abort === 1'b1) ab_seen <= 1'b1;
    end

    function automatic logic [7:0] col_of(input logic [7:0] c, input int k);
        return 8'(c + k);
    endfunction

    task automatic final_report;
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] op, input int na,
        input logic [31:0] a, input int nd, input bit q, input int ex);
        st_seen = 1'b0;
        rs_seen = 1'b0;
        ab_seen = 1'b0;
        host_u.frame(op, na, a, nd, q, ex);
    endtask

    task automatic wait_idle;
        // Recovery runs at its full default length
        for (int i = 0; i < 2000 && (busy !== 1'b0 || rbusy !== 1'b0); i++)
            @(posedge i_sys_clk);
        #1;
    endtask

    task automatic cfg(input logic fb, input logic tb, input logic [3:0] lv);
        @(posedge i_sys_clk);
        four_b <= fb;
        tob <= tb;
        lvl <= lv;
        @(posedge i_sys_clk);
    endtask

    task automatic run(input logic [7:0] op, input int na,
        input logic [31:0] a, input int nd, input bit q, input int ex,
        input logic ok, input sfps_op_t k);
        send(OPC_SET_WRITE_LATCH_CMD, 0, 32'h0, 0, 0, 0);
        check("latch set", write_enable_latch, 1'b1);
        send(op, na, a, nd, q, ex);
        check("op started", st_seen, ok);
        if (ok) begin
            check("op kind", st_kind, k);
            if (na > 0) check("op addr", st_addr, a);
            check("busy", busy, 1'b1);
            check("latch cleared", write_enable_latch, 1'b0);
            wait_idle;
            check("busy end", busy, 1'b0);
        end else begin
            check("latch kept", write_enable_latch, 1'b1);
        end
    endtask

    task automatic prog(input logic [7:0] op, input logic [7:0] col,
        input int nd);
        for (int i = 0; i < 256; i++) exp_v[i] = 1'b0;
        for (int k = 0; k < nd; k++) begin
            host_u.dat[k] = 8'($random(seed));
            exp_d[col_of(col, k)] = host_u.dat[k];
            exp_v[col_of(col, k)] = 1'b1;
        end
        run(op, 3, {8'h0, 16'($random(seed)), col}, nd, 1, 0, 1, OP_PROG);
        for (int i = 0; i < 256; i++) begin
            @(posedge i_sys_clk) idx <= 8'(i);
            repeat (2) @(posedge i_sys_clk);
            #1;
            check("pbuf valid", pvalid, exp_v[i]);
            if (exp_v[i]) check("pbuf data", pdata, exp_d[i]);
        end
    endtask

    initial begin
        #1_000_000;
        err_count++;
        final_report;
    end

    initial begin
        logic [31:0] a;
        seed = 32'hf8f1f3c4;
        err_count = 0;
        comparisons = 0;
        // Late in time zero, so the link toggle sees a reset edge
        {i_srst, four_b, tob, lvl, idx} <= {3'b101, 4'h0, 8'h0};
        {st_seen, rs_seen, ab_seen} = 3'b000;
        repeat (6) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        for (int i = 0; i < 8; i++) begin
            a = kinds[i] == OP_CHIP ? 32'h0 : {8'h0, 24'($random(seed))};
            run(ops[i], kinds[i] == OP_CHIP ? 0 : 3, a, 0, 0, 0, 1, kinds[i]);
        end
        send(OPC_SE_A, 3, a, 0, 0, 0);
        check("no latch", st_seen, 1'b0);
        run(OPC_SE_A, 3, a, 0, 0, 1, 0, OP_SEC);
        run(OPC_CE_A, 1, 0, 0, 0, 0, 0, OP_CHIP);
        run(OPC_EPP_A, 3, a, 4, 1, 1, 0, OP_PROG);
        cfg(0, 1, 1);
        run(OPC_SE_B, 3, 32'h0000ABCD, 0, 0, 0, 0, OP_SEC);
        run(OPC_B32_A, 3, 32'h00008000, 0, 0, 0, 0, OP_BLK32);
        run(OPC_B64_B, 3, 32'h0000FFFF, 0, 0, 0, 0, OP_BLK64);
        run(OPC_EPP_B, 3, 32'h00000100, 1, 1, 0, 0, OP_PROG);
        run(OPC_CE_B, 0, 0, 0, 0, 0, 0, OP_CHIP);
        run(OPC_SE_A, 3, 32'h00050000, 0, 0, 0, 1, OP_SEC);
        cfg(0, 0, 1);
        run(OPC_SE_A, 3, 32'h00FF1234, 0, 0, 0, 0, OP_SEC);
        run(OPC_SE_A, 3, 32'h00001234, 0, 0, 0, 1, OP_SEC);
        cfg(0, 1, 4);
        run(OPC_SE_A, 3, 32'h0007FFFF, 0, 0, 0, 0, OP_SEC);
        run(OPC_SE_A, 3, 32'h00080000, 0, 0, 0, 1, OP_SEC);
        cfg(1, 1, 0);
        run(OPC_SE_B, 4, a, 0, 0, 0, 1, OP_SEC);
        run(OPC_SE_B, 3, a, 0, 0, 0, 0, OP_SEC);
        cfg(0, 1, 0);
        prog(OPC_EPP_A, 8'hF0, 20);
        prog(OPC_EPP_B, 8'($random(seed)), 300);
        send(OPC_SET_WRITE_LATCH_CMD, 0, 0, 0, 0, 0);
        send(OPC_CE_B, 0, 0, 0, 0, 0);
        send(OPC_RST_EN, 0, 0, 0, 0, 0);
        send(OPC_RST, 0, 0, 0, 0, 0);
        check("soft reset", rs_seen, 1'b1);
        check("abort", ab_seen, 1'b1);
        check("recovery", rbusy, 1'b1);
        send(OPC_SET_WRITE_LATCH_CMD, 0, 0, 0, 0, 0);
        check("latch in recovery", write_enable_latch, 1'b0);
        wait_idle;
        send(OPC_RST_EN, 0, 0, 0, 0, 0);
        send(OPC_SET_WRITE_LATCH_CMD, 0, 0, 0, 0, 0);
        send(OPC_RST, 0, 0, 0, 0, 0);
        check("cancelled reset", rs_seen, 1'b0);
        send(OPC_RST_EN, 0, 0, 0, 0, 0);
        send(OPC_RST, 0, 0, 0, 0, 0);
        check("idle reset", rs_seen, 1'b1);
        check("latch after reset", write_enable_latch, 1'b0);
        wait_idle;
        final_report;
    end
endmodule

`default_nettype wire

// File: sim/sfps_host_model.sv
// Purpose: Host controller model driving frames into the sequencer
// Assumes: Serial clock runs only inside a frame
// Notes:   Released lines flip so stale values never pass
`default_nettype none

module sfps_host_model (
    output logic o_sclk, // Serial clock
    output logic o_cs_n, // Chip select
    output logic [3:0] o_io // Data lines
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] dat [0:299];

    // Late in time zero, so select's rise clears the live flag
    initial begin
        o_sclk <= 1'b0;
        o_cs_n <= 1'b1;
        o_io <= 4'h5;
    end

    task automatic clk_out(input logic [3:0] v);
        o_io = v;
        #3 o_sclk = 1'b1;
        #3 o_sclk = 1'b0;
    endtask

    task automatic put(input logic [7:0] b, input bit quad);
        if (quad) begin
            clk_out(b[7:4]);
            clk_out(b[3:0]);
        end else begin
            for (int i = 7; i >= 0; i--)
                clk_out({~o_io[3:1], b[i]});
        end
    endtask

    task automatic frame(input logic [7:0] op, input int na,
        input logic [31:0] a, input int nd, input bit quad, input int extra);
        o_cs_n = 1'b0;
        #3;
        put(op, 1'b0);
        for (int k = na - 1; k >= 0; k--)
            put(a[8*k +: 8], quad);
        for (int k = 0; k < nd; k++)
            put(dat[k], quad);
        repeat (extra) clk_out(~o_io);
        #3 o_cs_n = 1'b1;
        o_io = ~o_io;
        #300;
    endtask
endmodule

`default_nettype wire

// File: sim/sfps_props.sv
// Purpose: Port-level checks of the flash sequencer
// Assumes: One clock domain, synchronous reset
// Notes:   Op length check takes age_r from two cycles under to one over the set time
`default_nettype none

module sfps_props
    import sfps_pkg::*;
#(
    parameter int unsigned PROG_US = 1,
    parameter int unsigned SEC_US = 1,
    parameter int unsigned B32_US = 1,
    parameter int unsigned B64_US = 2,
    parameter int unsigned CHIP_US = 3
) (
    input wire logic i_sys_clk, // Clock
    input wire logic i_srst, // Reset
    input wire logic [3:0] i_protect_level, // Protect level
    input wire logic o_write_enable_latch, // Latch
    input wire logic o_op_in_progress_flag, // Busy
    input wire logic o_reset_busy, // Recovery
    input wire logic o_op_start, // Start pulse
    input wire sfps_pkg::sfps_op_t o_op_kind, // Kind
    input wire logic o_op_done, // Done pulse
    input wire logic o_soft_reset // Reset pulse
);
    logic [31:0] age_r;
    logic [31:0] want;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || o_op_start)
            age_r <= 32'h0;
        else
            age_r <= age_r + 32'h1;
    end

    always_comb begin
        case (o_op_kind)
            OP_PROG: want = PROG_US * CLK_MHZ;
            OP_SEC: want = SEC_US * CLK_MHZ;
            OP_BLK32: want = B32_US * CLK_MHZ;
            OP_BLK64: want = B64_US * CLK_MHZ;
            default: want = CHIP_US * CLK_MHZ;
        endcase
    end

    a_start_sets_busy: assert property (
        o_op_start |=> o_op_in_progress_flag)
        else $error("busy flag not raised after start");
    a_start_clears_latch: assert property (
        o_op_start |-> ##[0:1] !o_write_enable_latch)
        else $error("latch still set after start");
    a_start_needs_latch: assert property (
        o_op_start |-> $past(o_write_enable_latch))
        else $error("op started without latch");
    a_no_start_busy: assert property (
        o_op_start |-> !$past(o_op_in_progress_flag))
        else $error("op started while busy");
    a_op_length: assert property (
        o_op_done |-> (age_r + 32'h2 >= want) && (age_r <= want + 32'h1))
        else $error("op length wrong for kind");
    a_done_drops_busy: assert property (
        o_op_done |-> !o_op_in_progress_flag && $past(o_op_in_progress_flag))
        else $error("done without busy falling");
    a_chip_unprot: assert property (
        o_op_start && o_op_kind == OP_CHIP |-> i_protect_level == 4'h0)
        else $error("chip erase ran while protected");
    a_reset_clears: assert property (
        o_soft_reset |-> ##[0:1] (!o_write_enable_latch
            && !o_op_in_progress_flag && o_reset_busy))
        else $error("soft reset left state behind");
    a_recov_no_start: assert property (
        o_reset_busy |-> !o_op_start)
        else $error("op started during recovery");
endmodule

bind sfps_flash_seq sfps_props #(.PROG_US(PROG_US), .SEC_US(SEC_US),
    .B32_US(B32_US), .B64_US(B64_US), .CHIP_US(CHIP_US)) props_u (
    .i_sys_clk, .i_srst, .i_protect_level, .o_write_enable_latch,
    .o_op_in_progress_flag, .o_reset_busy, .o_op_start, .o_op_kind,
    .o_op_done, .o_soft_reset);

`default_nettype wire
